// ==== hdl/slc_config_regs.v ====
/*
  sensor link configuration register group: protocol select, slave position
  address and two source tag registers, with deferred protocol changes,
  otp-backed address handling and register array error detection.
  assumes: the protocol engines present one register access at a time on
  the access port in the order received; otp values arrive on plain inputs
  from logic on the same clock and are stable once otp_valid_in is high.
*/
// Notes on behaviour
// [RL1] protocol select accessible only in dsi3/psi5 diagnostic
// [RL2] bits 2:0 pick protocol, pin, undervoltage
// [RL3] protocol-disabling changes wait for next reset
// [RL4] dsi3 to psi5 change keeps dsi3 until reset
// [RL5] register accesses complete in order received
// [RL6] no protocol select write during region two commit
// [RL7] all four registers under array error detection
// [RL8] zero otp address: address assigned at run time
// [RL9] nonzero otp address: discovery ignored, otp address used
// [RL10] locked region two restores otp address each reset
// [RL11] psi5: position address stored but without effect
// [RL12] position address 4 bits, upper bits zero
// [RL13] source tags accessible only in dsi3/psi5 diagnostic
// [RL14] enable bit 7, format 6:4, tag 3:0
// [RL15] enable bit turns its data source on
// [RL16] dsi3 format selects periodic field widths
// [RL17] psi5 uses ten data bits for any format
// [RL18] registers reset to zero, reserved bits stored
`timescale 1ns/100ps
`include "slc_map.vh"

module slc_config_regs
(
  input wire clk_in,
  input wire reset_in,
  // register access port from the protocol engines
  input wire access_valid_in,
  input wire access_write_in,
  input wire [7:0] access_addr_in,
  input wire [7:0] access_wdata_in,
  input wire crm_write_in,
  input wire psi5_diag_mode_in,
  output reg access_done_out,
  output reg [7:0] access_rdata_out,
  output reg [1:0] access_resp_out,
  // run-time address assignment from discovery
  input wire discovery_assign_in,
  input wire [3:0] discovery_addr_in,
  // otp interface
  input wire otp_valid_in,
  input wire [7:0] otp_protocol_select_in,
  input wire [7:0] otp_position_addr_in,
  input wire region_two_locked_in,
  input wire region_two_commit_in,
  output reg region_two_crc_fail_out,
  // resulting configuration
  output reg [2:0] active_protocol_out,
  output reg dsi3_active_out,
  output reg psi5_active_out,
  output reg psi5_test_enable_out,
  output reg bus_switch_pin_out,
  output reg interrupt_pin_out,
  output reg undervoltage_detect_out,
  output reg discovery_enable_out,
  output reg [3:0] slave_address_out,
  output reg primary_source_enable_out,
  output reg secondary_source_enable_out,
  output reg [3:0] primary_source_tag_out,
  output reg [3:0] secondary_source_tag_out,
  output reg [2:0] tag_width_out,
  output reg [1:0] keepalive_width_out,
  output reg [2:0] status_width_out,
  output reg [4:0] data_width_out,
  output reg array_error_out
);

  wire [7:0] protocol_select; // stored protocol select byte
  wire [7:0] position_addr; // stored position address byte
  wire [7:0] primary_source_tag; // first source tag byte
  wire [7:0] secondary_source_tag; // second source tag byte
  wire [3:0] parity_err; // one mismatch flag per register
  reg [2:0] latched_protocol; // protocol frozen since the last reset
  reg boot_pending; // otp reload not yet done since reset
  reg commit_write_seen; // protocol select touched during commit
  wire accessible; // dsi3 or psi5 diagnostic
  wire hit_proto; // decoded offsets
  wire hit_paddr;
  wire hit_tag0;
  wire hit_tag1;
  wire mapped;
  wire do_write; // accepted write this cycle
  wire paddr_load; // otp reload or discovery assignment
  wire [7:0] paddr_load_value;
  wire boot_load; // single reload cycle after reset
  wire [2:0] fmt_tag_w;
  wire [1:0] fmt_ka_w;
  wire [2:0] fmt_st_w;
  wire [4:0] fmt_data_w;
  reg [7:0] next_rdata;
  reg [1:0] next_resp;

  // psi5 normal mode locks the registers; psi5 diagnostic opens them
  assign accessible = dsi3_active_out | psi5_diag_mode_in; // RL1 RL13

  // address decode of the four offsets
  assign hit_proto = (access_addr_in == `SLC_PROTOCOL_SELECT_OFS);
  assign hit_paddr = (access_addr_in == `SLC_POSITION_ADDR_OFS);
  assign hit_tag0 = (access_addr_in == `SLC_PRIMARY_TAG_OFS);
  assign hit_tag1 = (access_addr_in == `SLC_SECONDARY_TAG_OFS);
  assign mapped = hit_proto | hit_paddr | hit_tag0 | hit_tag1;

  // a write lands only when mapped and permitted
  assign do_write = access_valid_in & access_write_in & accessible;

  // reload happens on the first cycle otp is valid after reset
  assign boot_load = boot_pending & otp_valid_in;

  // locked region two forces otp address back on each reset; a nonzero
  // otp address also wins, otherwise discovery may assign one
  assign paddr_load = (boot_load & (region_two_locked_in |
    (otp_position_addr_in[`SLC_PADDR_MSB:0] != 4'h0))) |
    (discovery_assign_in & discovery_enable_out); // RL10 RL8 RL9
  assign paddr_load_value = boot_load ?
    {4'h0, otp_position_addr_in[`SLC_PADDR_MSB:0]} :
    {4'h0, discovery_addr_in}; // RL12

  // protocol select register; otp value restored at boot
  slc_reg8 u_protocol_select
  (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .write_in(do_write & hit_proto),
    .data_in(access_wdata_in),
    .load_value_in(otp_protocol_select_in),
    .load_in(boot_load),
    .value_out(protocol_select),
    .parity_error_out(parity_err[0])
  );

  // position address register; upper nibble always written as zero
  slc_reg8 u_position_addr
  (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .write_in(do_write & hit_paddr & (crm_write_in | psi5_active_out)),
    .data_in({4'h0, access_wdata_in[`SLC_PADDR_MSB:0]}),
    .load_value_in(paddr_load_value),
    .load_in(paddr_load),
    .value_out(position_addr),
    .parity_error_out(parity_err[1])
  ); // RL12

  // primary source tag register, reserved-free layout
  slc_reg8 u_primary_tag
  (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .write_in(do_write & hit_tag0),
    .data_in(access_wdata_in),
    .load_value_in(`SLC_REG_RESET),
    .load_in(1'b0),
    .value_out(primary_source_tag),
    .parity_error_out(parity_err[2])
  );

  // secondary source tag register; bits 6:4 stored, unused
  slc_reg8 u_secondary_tag
  (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .write_in(do_write & hit_tag1),
    .data_in(access_wdata_in),
    .load_value_in(`SLC_REG_RESET),
    .load_in(1'b0),
    .value_out(secondary_source_tag),
    .parity_error_out(parity_err[3])
  ); // RL18

  // boot reload sequencing
  always @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      boot_pending <= 1'b1;
    end
    else if (otp_valid_in)
    begin
      boot_pending <= 1'b0;
    end
  end

  // protocol in force is sampled only at boot: later register writes,
  // even to otp, never switch a running link off
  always @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      latched_protocol <= `SLC_PROTO_DSI3_INT;
    end
    else if (boot_load)
    begin
      latched_protocol <= otp_protocol_select_in[`SLC_PROTO_MSB:0]; // RL3 RL4
    end
  end

  // commit guard: a protocol write during region two commit breaks crc;
  // the flag is sticky until the next commit starts clean
  always @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      commit_write_seen <= 1'b0;
      region_two_crc_fail_out <= 1'b0;
    end
    else
    begin
      if (region_two_commit_in & do_write & hit_proto)
      begin
        commit_write_seen <= 1'b1; // RL6
      end
      else if (!region_two_commit_in)
      begin
        commit_write_seen <= 1'b0;
      end
      // fail shown when a commit ends after a protocol write
      if (commit_write_seen & !region_two_commit_in)
      begin
        region_two_crc_fail_out <= 1'b1; // RL6
      end
      else if (region_two_commit_in & !commit_write_seen)
      begin
        region_two_crc_fail_out <= 1'b0;
      end
    end
  end

  // one access answered per cycle, strictly in arrival order
  always @*
  begin
    next_rdata = 8'h00;
    next_resp = `SLC_RESP_OK;
    if (!mapped)
    begin
      next_resp = `SLC_RESP_UNMAPPED;
    end
    else if (!accessible)
    begin
      next_resp = `SLC_RESP_DENIED; // RL1 RL13
    end
    else if (!access_write_in)
    begin
      case (1'b1)
        hit_proto: next_rdata = protocol_select;
        hit_paddr: next_rdata = position_addr;
        hit_tag0: next_rdata = primary_source_tag;
        default: next_rdata = secondary_source_tag;
      endcase
    end
  end

  // registered answer one cycle after the request
  always @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      access_done_out <= 1'b0;
      access_rdata_out <= 8'h00;
      access_resp_out <= `SLC_RESP_OK;
    end
    else
    begin
      access_done_out <= access_valid_in; // RL5
      if (access_valid_in)
      begin
        access_rdata_out <= next_rdata;
        access_resp_out <= next_resp;
      end
    end
  end

  // format field decode
  slc_format_decode u_format
  (
    .format_in(primary_source_tag[`SLC_FMT_MSB:`SLC_FMT_LSB]),
    .psi5_in(psi5_active_out),
    .tag_width_out(fmt_tag_w),
    .keepalive_width_out(fmt_ka_w),
    .status_width_out(fmt_st_w),
    .data_width_out(fmt_data_w)
  ); // RL14

  // configuration outputs follow the latched protocol and register values
  always @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      active_protocol_out <= `SLC_PROTO_DSI3_INT;
      dsi3_active_out <= 1'b1;
      psi5_active_out <= 1'b0;
      psi5_test_enable_out <= 1'b0;
      bus_switch_pin_out <= 1'b0;
      interrupt_pin_out <= 1'b1;
      undervoltage_detect_out <= 1'b0;
      discovery_enable_out <= 1'b1;
      slave_address_out <= 4'h0;
      primary_source_enable_out <= 1'b0;
      secondary_source_enable_out <= 1'b0;
      primary_source_tag_out <= 4'h0;
      secondary_source_tag_out <= 4'h0;
      tag_width_out <= 3'h0;
      keepalive_width_out <= 2'h2;
      status_width_out <= 3'h4;
      data_width_out <= 5'h0a;
      array_error_out <= 1'b0;
    end
    else
    begin
      active_protocol_out <= latched_protocol;
      // unlisted codes fall back to the dsi3 interrupt configuration
      case (latched_protocol) // RL2
        `SLC_PROTO_PSI5_SW:
        begin
          dsi3_active_out <= 1'b0;
          psi5_active_out <= 1'b1;
          psi5_test_enable_out <= 1'b1;
          bus_switch_pin_out <= 1'b1;
          interrupt_pin_out <= 1'b0;
          undervoltage_detect_out <= 1'b0;
        end
        `SLC_PROTO_DSI3_UV:
        begin
          dsi3_active_out <= 1'b1;
          psi5_active_out <= 1'b0;
          psi5_test_enable_out <= 1'b0;
          bus_switch_pin_out <= 1'b1;
          interrupt_pin_out <= 1'b0;
          undervoltage_detect_out <= 1'b1;
        end
        `SLC_PROTO_PSI5_UV:
        begin
          dsi3_active_out <= 1'b0;
          psi5_active_out <= 1'b1;
          psi5_test_enable_out <= 1'b1;
          bus_switch_pin_out <= 1'b1;
          interrupt_pin_out <= 1'b0;
          undervoltage_detect_out <= 1'b1;
        end
        default:
        begin
          dsi3_active_out <= 1'b1;
          psi5_active_out <= 1'b0;
          psi5_test_enable_out <= 1'b0;
          bus_switch_pin_out <= 1'b0;
          interrupt_pin_out <= 1'b1;
          undervoltage_detect_out <= 1'b0;
        end
      endcase
      // discovery only when otp holds no address and dsi3 runs
      discovery_enable_out <= dsi3_active_out &
        (otp_position_addr_in[`SLC_PADDR_MSB:0] == 4'h0); // RL8 RL9
      // psi5: address held but presented as zero to the link
      slave_address_out <= psi5_active_out ? 4'h0 :
        position_addr[`SLC_PADDR_MSB:0]; // RL11
      primary_source_enable_out <=
        primary_source_tag[`SLC_ENABLE_BIT]; // RL15
      secondary_source_enable_out <=
        secondary_source_tag[`SLC_ENABLE_BIT]; // RL15
      primary_source_tag_out <= primary_source_tag[`SLC_TAG_MSB:0];
      secondary_source_tag_out <= secondary_source_tag[`SLC_TAG_MSB:0];
      tag_width_out <= fmt_tag_w; // RL16 RL17
      keepalive_width_out <= fmt_ka_w;
      status_width_out <= fmt_st_w;
      data_width_out <= fmt_data_w;
      array_error_out <= |parity_err; // RL7
    end
  end

endmodule // slc_config_regs

// ==== hdl/slc_map.vh ====
/*
  register offsets, field positions, reset values and protocol codes for
  the sensor link configuration register group.
  assumes: included by bare name from the design files under hdl/.
*/
`ifndef SLC_MAP_VH
`define SLC_MAP_VH

// register offsets on the internal register port
`define SLC_PROTOCOL_SELECT_OFS 8'h16
`define SLC_POSITION_ADDR_OFS 8'h18
`define SLC_PRIMARY_TAG_OFS 8'h1a
`define SLC_SECONDARY_TAG_OFS 8'h1b

// reset value shared by all four registers
`define SLC_REG_RESET 8'h00

// field positions
`define SLC_PROTO_MSB 2
`define SLC_PADDR_MSB 3
`define SLC_TAG_MSB 3
`define SLC_FMT_MSB 6
`define SLC_FMT_LSB 4
`define SLC_ENABLE_BIT 7

// protocol select codes
`define SLC_PROTO_DSI3_INT 3'h0
`define SLC_PROTO_PSI5_SW 3'h1
`define SLC_PROTO_DSI3_UV 3'h3
`define SLC_PROTO_PSI5_UV 3'h5

// access outcome codes
`define SLC_RESP_OK 2'h0
`define SLC_RESP_DENIED 2'h1
`define SLC_RESP_UNMAPPED 2'h2

`endif

// ==== hdl/slc_reg8.v ====
/*
  one 8-bit configuration register with a per-register parity bit.
  assumes: single clock, asynchronous active-high reset, write strobe from
  the same clock domain.
*/
`timescale 1ns/100ps
`include "slc_map.vh"

module slc_reg8
(
  input wire clk_in,
  input wire reset_in,
  input wire write_in,
  input wire [7:0] data_in,
  input wire [7:0] load_value_in,
  input wire load_in,
  output reg [7:0] value_out,
  output wire parity_error_out
);

  reg parity; // even parity stored alongside the value

  // store a write or a load (reset-time reload or discovery assignment); a load wins over a write
  always @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      value_out <= `SLC_REG_RESET; // RL18
      parity <= 1'b0;
    end
    else if (load_in)
    begin
      value_out <= load_value_in;
      parity <= ^load_value_in;
    end
    else if (write_in)
    begin
      value_out <= data_in;
      parity <= ^data_in;
    end
  end

  // any odd number of flipped bits in the stored byte shows as a mismatch
  assign parity_error_out = (^value_out) ^ parity; // RL7

endmodule // slc_reg8

// ==== hdl/slc_format_decode.v ====
/*
  decodes the periodic frame format field into field widths.
  assumes: purely combinational, inputs already on the register clock.
*/
`timescale 1ns/100ps
`include "slc_map.vh"

module slc_format_decode
(
  input wire [2:0] format_in,
  input wire psi5_in,
  output reg [2:0] tag_width_out,
  output reg [1:0] keepalive_width_out,
  output reg [2:0] status_width_out,
  output reg [4:0] data_width_out
);

  // dsi3 table; psi5 always uses a bare 10-bit data field
  always @*
  begin
    tag_width_out = 3'h0;
    keepalive_width_out = 2'h0;
    status_width_out = 3'h0;
    data_width_out = 5'h0a;
    if (!psi5_in) // RL16
    begin
      case (format_in)
        3'h0:
        begin
          keepalive_width_out = 2'h2;
          status_width_out = 3'h4;
        end
        3'h1:
        begin
          tag_width_out = 3'h4;
          keepalive_width_out = 2'h2;
          status_width_out = 3'h4;
        end
        3'h2:
        begin
          status_width_out = 3'h4;
          data_width_out = 5'h0c;
        end
        3'h3:
        begin
          tag_width_out = 3'h4;
          status_width_out = 3'h4;
          data_width_out = 5'h0c;
        end
        3'h4:
        begin
          keepalive_width_out = 2'h2;
        end
        3'h5:
        begin
          data_width_out = 5'h10;
        end
        3'h6:
        begin
          status_width_out = 3'h4;
          data_width_out = 5'h10;
        end
        default:
        begin
          tag_width_out = 3'h4;
          status_width_out = 3'h4;
          data_width_out = 5'h10;
        end
      endcase
    end
    // psi5 leaves the 10-bit default for every format value
    // RL17
  end

endmodule // slc_format_decode

// ==== tb/slc_config_regs_asserts.sv ====
/*
  port assertions for the configuration register group.
  assumes: bound to slc_config_regs, one clock, async high reset.
*/
`timescale 1ns/100ps

module slc_config_regs_asserts
(
  input wire clk_in,
  input wire reset_in,
  input wire access_valid_in,
  input wire access_write_in,
  input wire [7:0] access_addr_in,
  input wire psi5_diag_mode_in,
  input wire access_done_out,
  input wire [7:0] access_rdata_out,
  input wire [1:0] access_resp_out,
  input wire [2:0] active_protocol_out,
  input wire dsi3_active_out,
  input wire psi5_active_out,
  input wire [3:0] slave_address_out,
  input wire [4:0] data_width_out,
  input wire array_error_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);
  // one of the four group offsets
  wire mapped = access_addr_in == 8'h16 || access_addr_in == 8'h18 ||
    access_addr_in == 8'h1a || access_addr_in == 8'h1b;
  // psi5 outside diagnostic mode shuts the port
  wire shut = !dsi3_active_out && !psi5_diag_mode_in;
  // protocol write: in force value must not move
  sequence proto_write_s;
    access_valid_in && access_write_in && access_addr_in == 8'h16;
  endsequence
  sequence proto_hold_s;
    $stable(active_protocol_out) [*2];
  endsequence
  sequence paddr_read_s;
    access_valid_in && !access_write_in && access_addr_in == 8'h18 && !shut;
  endsequence
  // psi5 active now; the checks below also need it a cycle earlier, so boot decode has landed
  wire psi5_steady = psi5_active_out;

  done_follows_a: assert property (access_valid_in |=> access_done_out)
    else $error("no answer one cycle after request");
  done_cause_a: assert property (
    access_done_out |-> $past(access_valid_in))
    else $error("answer without request");
  denied_a: assert property (
    access_valid_in && mapped && shut |=> access_resp_out == 2'h1)
    else $error("access not refused outside diagnostic mode");
  paddr_upper_a: assert property (
    paddr_read_s |=> access_rdata_out[7:4] == 4'h0)
    else $error("position address upper bits not zero");
  proto_defer_a: assert property (proto_write_s |=> proto_hold_s)
    else $error("protocol changed without reset");
  proto_excl_a: assert property (
    !(dsi3_active_out && psi5_active_out))
    else $error("both protocols active");
  psi5_width_a: assert property (
    psi5_steady && $past(psi5_steady) |-> data_width_out == 5'h0a)
    else $error("psi5 data width not ten");
  psi5_addr_a: assert property (
    psi5_steady && $past(psi5_steady) |-> slave_address_out == 4'h0)
    else $error("position address acts in psi5");
  array_ok_a: assert property (!array_error_out)
    else $error("register array error without fault");
endmodule // slc_config_regs_asserts

// ==== tb/slc_master_model.sv ====
/*
  bus master model: issues register accesses on the access port.
  assumes: answer pulse comes one cycle after the strobe.
*/
`timescale 1ns/100ps

module slc_master_model
(
  input wire clk_in,
  input wire access_done_in,
  input wire [7:0] access_rdata_in,
  input wire [1:0] access_resp_in,
  output reg access_valid_out,
  output reg access_write_out,
  output reg [7:0] access_addr_out,
  output reg [7:0] access_wdata_out,
  output reg crm_write_out
);
  // idle port at time zero
  initial
  begin
    access_valid_out = 1'b0;
    access_write_out = 1'b0;
    access_addr_out = 8'h00;
    access_wdata_out = 8'h00;
    crm_write_out = 1'b0;
  end

  // set all request lines at once, off the sampling edge
  task drive(input v, input w, input [7:0] a, input [7:0] d, input c);
    begin
      access_valid_out = v;
      access_write_out = w;
      access_addr_out = a;
      access_wdata_out = d;
      crm_write_out = c;
    end
  endtask

  // single access; released lines show inverted garbage, not old values
  task xfer(input w, input [7:0] a, input [7:0] d, input c,
    output [7:0] rd, output [1:0] rs);
    integer k;
    begin
      @(negedge clk_in);
      drive(1'b1, w, a, d, c);
      @(negedge clk_in);
      drive(1'b0, ~w, ~a, ~d, 1'b0);
      k = 0;
      while (access_done_in !== 1'b1 && k < 4)
      begin
        @(negedge clk_in);
        k = k + 1;
      end
      rd = access_rdata_in;
      // a lost answer shows as a code the design never gives
      rs = (k < 4) ? access_resp_in : 2'h3;
    end
  endtask

  // write then read the same offset on consecutive cycles
  task b2b(input [7:0] a, input [7:0] d, output [7:0] rd);
    begin
      @(negedge clk_in);
      drive(1'b1, 1'b1, a, d, 1'b0);
      @(negedge clk_in);
      drive(1'b1, 1'b0, a, ~d, 1'b0);
      @(negedge clk_in);
      drive(1'b0, 1'b0, ~a, d, 1'b0);
      @(negedge clk_in);
      rd = access_rdata_in;
    end
  endtask
endmodule // slc_master_model

// ==== tb/slc_config_regs_tb.sv ====
/*
  bench for slc_config_regs: master model, otp and discovery stimulus.
  assumes: hdl/ files compiled first, checker bound below.
*/
`timescale 1ns/100ps

module slc_config_regs_tb;
  reg clk_in, reset_in, diag, disc, otp_v, lock, commit;
  reg [3:0] disc_addr;
  reg [7:0] otp_p, otp_a, rd;
  reg [1:0] rs;
  reg [12:0] fx;
  reg [2:0] cx;
  wire v, w, cw, done, d3, p5, tst, bsw, irq, uv, den, crc, pe, se, aerr;
  wire [7:0] a, d, rdata;
  wire [1:0] resp, kw;
  wire [2:0] ap, tw, sw;
  wire [4:0] dw;
  wire [3:0] sa, pt, st;
  wire [7:0] fl = {2'h0, d3, p5, tst, bsw, irq, uv};
  integer n_errors, cmp_count, cyc, i;

  slc_config_regs uut (.clk_in(clk_in), .reset_in(reset_in),
    .access_valid_in(v), .access_write_in(w), .access_addr_in(a),
    .access_wdata_in(d), .crm_write_in(cw), .psi5_diag_mode_in(diag),
    .access_done_out(done), .access_rdata_out(rdata),
    .access_resp_out(resp), .discovery_assign_in(disc),
    .discovery_addr_in(disc_addr), .otp_valid_in(otp_v),
    .otp_protocol_select_in(otp_p), .otp_position_addr_in(otp_a),
    .region_two_locked_in(lock), .region_two_commit_in(commit),
    .region_two_crc_fail_out(crc), .active_protocol_out(ap),
    .dsi3_active_out(d3), .psi5_active_out(p5),
    .psi5_test_enable_out(tst), .bus_switch_pin_out(bsw),
    .interrupt_pin_out(irq), .undervoltage_detect_out(uv),
    .discovery_enable_out(den), .slave_address_out(sa),
    .primary_source_enable_out(pe), .secondary_source_enable_out(se),
    .primary_source_tag_out(pt), .secondary_source_tag_out(st),
    .tag_width_out(tw), .keepalive_width_out(kw),
    .status_width_out(sw), .data_width_out(dw), .array_error_out(aerr));

  slc_master_model master (.clk_in(clk_in), .access_done_in(done),
    .access_rdata_in(rdata), .access_resp_in(resp),
    .access_valid_out(v), .access_write_out(w), .access_addr_out(a),
    .access_wdata_out(d), .crm_write_out(cw));

  // expected {tag, keepalive, status, data} widths per dsi3 format
  function [12:0] fw(input [2:0] f);
    case (f)
      3'h0: fw = {3'h0, 2'h2, 3'h4, 5'h0a};
      3'h1: fw = {3'h4, 2'h2, 3'h4, 5'h0a};
      3'h2: fw = {3'h0, 2'h0, 3'h4, 5'h0c};
      3'h3: fw = {3'h4, 2'h0, 3'h4, 5'h0c};
      3'h4: fw = {3'h0, 2'h2, 3'h0, 5'h0a};
      3'h5: fw = {3'h0, 2'h0, 3'h0, 5'h10};
      3'h6: fw = {3'h0, 2'h0, 3'h4, 5'h10};
      default: fw = {3'h4, 2'h0, 3'h4, 5'h10};
    endcase
  endfunction

  // expected dsi3, psi5, test, bus switch, interrupt, undervoltage
  function [5:0] cf(input [2:0] c);
    case (c)
      3'h0: cf = 6'h22;
      3'h1: cf = 6'h1c;
      3'h3: cf = 6'h25;
      default: cf = 6'h1d;
    endcase
  endfunction

  task chk_data(input [7:0] got, input [7:0] want);
    begin
      cmp_count = cmp_count + 1;
      if (got !== want)
      begin
        n_errors = n_errors + 1;
        $display("unexpected at %0t: data %h not %h", $time, got, want);
      end
    end
  endtask

  task chk_resp(input [1:0] got, input [1:0] want);
    begin
      cmp_count = cmp_count + 1;
      if (got !== want)
      begin
        n_errors = n_errors + 1;
        $display("unexpected at %0t: resp %h not %h", $time, got, want);
      end
    end
  endtask

  task rdreg(input [7:0] ad, input [7:0] want);
    begin
      master.xfer(1'b0, ad, 8'h00, 1'b0, rd, rs);
      chk_resp(rs, 2'h0);
      chk_data(rd, want);
    end
  endtask

  task wrreg(input [7:0] ad, input [7:0] wd, input c);
    master.xfer(1'b1, ad, wd, c, rd, rs);
  endtask

  task settle;
    repeat (2) @(negedge clk_in);
  endtask

  task pulse_disc;
    begin
      disc = 1'b1;
      @(negedge clk_in);
      disc = 1'b0;
      settle;
    end
  endtask

  // device reset with given otp contents, then otp reload
  task boot(input [7:0] p, input [7:0] pa, input l);
    begin
      otp_p = p;
      otp_a = pa;
      lock = l;
      otp_v = 1'b0;
      reset_in = 1'b1;
      repeat (12) @(negedge clk_in);
      reset_in = 1'b0;
      @(negedge clk_in);
      otp_v = 1'b1;
      repeat (3) @(negedge clk_in);
    end
  endtask

  task test_done;
    begin
      $display("errors %0d, comparisons %0d", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask

  initial
  begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end

  // hang guard
  always @(posedge clk_in)
  begin
    cyc = cyc + 1;
    if (cyc == 5000)
    begin
      n_errors = n_errors + 1;
      test_done;
    end
  end

  initial
  begin
    n_errors = 0;
    cmp_count = 0;
    cyc = 0;
    diag = 1'b0;
    disc = 1'b0;
    disc_addr = 4'h0;
    commit = 1'b0;
    boot(8'h00, 8'h00, 1'b0);
    rdreg(8'h16, 8'h00);
    rdreg(8'h18, 8'h00);
    rdreg(8'h1a, 8'h00);
    rdreg(8'h1b, 8'h00);
    chk_data(fl, {2'h0, cf(3'h0)});
    fx = fw(3'h0);
    chk_data({tw, kw, sw}, fx[12:5]);
    chk_data({6'h0, aerr, den}, 8'h01);
    master.xfer(1'b0, 8'h17, 8'h00, 1'b0, rd, rs);
    chk_resp(rs, 2'h2);
    wrreg(8'h16, 8'hf9, 1'b0);
    rdreg(8'h16, 8'hf9);
    settle;
    chk_data({5'h0, ap}, 8'h00);
    chk_data(fl, {2'h0, cf(3'h0)});
    // protocol write inside a region two commit
    commit = 1'b1;
    wrreg(8'h16, 8'h00, 1'b0);
    commit = 1'b0;
    settle;
    chk_data({7'h0, crc}, 8'h01);
    commit = 1'b1;
    settle;
    chk_data({7'h0, crc}, 8'h00);
    commit = 1'b0;
    wrreg(8'h18, 8'ha5, 1'b1);
    rdreg(8'h18, 8'h05);
    wrreg(8'h18, 8'h03, 1'b0);
    rdreg(8'h18, 8'h05);
    settle;
    chk_data({4'h0, sa}, 8'h05);
    disc_addr = 4'h9;
    pulse_disc;
    chk_data({4'h0, sa}, 8'h09);
    for (i = 0; i < 8; i = i + 1)
    begin
      wrreg(8'h1a, {1'b1, i[2:0], 1'b0, i[2:0]}, 1'b0);
      settle;
      fx = fw(i[2:0]);
      chk_data({tw, kw, sw}, fx[12:5]);
      chk_data({3'h0, dw}, {3'h0, fx[4:0]});
      chk_data({3'h0, pe, pt}, {4'h1, 1'b0, i[2:0]});
    end
    wrreg(8'h1b, 8'hfa, 1'b0);
    rdreg(8'h1b, 8'hfa);
    settle;
    chk_data({3'h0, se, st}, 8'h1a);
    master.b2b(8'h1b, 8'h0a, rd);
    chk_data(rd, 8'h0a);
    settle;
    chk_data({3'h0, se, st}, 8'h0a);
    boot(8'h00, 8'h07, 1'b1);
    rdreg(8'h18, 8'h07);
    chk_data({3'h0, den, sa}, 8'h07);
    disc_addr = 4'h2;
    pulse_disc;
    chk_data({4'h0, sa}, 8'h07);
    wrreg(8'h18, 8'h02, 1'b1);
    boot(8'h00, 8'h07, 1'b1);
    rdreg(8'h18, 8'h07);
    // codes 1, 3, 5 each take force only through a reset
    for (i = 0; i < 3; i = i + 1)
    begin
      cx = 2 * i + 1;
      boot({5'h0, cx}, 8'h07, 1'b0);
      chk_data(fl, {2'h0, cf(cx)});
      chk_data({5'h0, ap}, {5'h0, cx});
      master.xfer(1'b0, 8'h1a, 8'h00, 1'b0, rd, rs);
      chk_resp(rs, {1'b0, cx != 3'h3});
      diag = 1'b1;
      wrreg(8'h18, 8'h0c, 1'b0);
      rdreg(8'h18, (cx == 3'h3) ? 8'h07 : 8'h0c);
      wrreg(8'h1a, 8'h70, 1'b0);
      settle;
      chk_data({3'h0, dw}, (cx != 3'h3) ? 8'h0a : 8'h10);
      chk_data({4'h0, sa}, (cx != 3'h3) ? 8'h00 : 8'h07);
      diag = 1'b0;
    end
    test_done;
  end
endmodule // slc_config_regs_tb

bind slc_config_regs slc_config_regs_asserts chk (.clk_in(clk_in),
  .reset_in(reset_in), .access_valid_in(access_valid_in),
  .access_write_in(access_write_in), .access_addr_in(access_addr_in),
  .psi5_diag_mode_in(psi5_diag_mode_in),
  .access_done_out(access_done_out), .access_rdata_out(access_rdata_out),
  .access_resp_out(access_resp_out),
  .active_protocol_out(active_protocol_out),
  .dsi3_active_out(dsi3_active_out), .psi5_active_out(psi5_active_out),
  .slave_address_out(slave_address_out), .data_width_out(data_width_out),
  .array_error_out(array_error_out));
